// File: rtl/pebc_pin_assign.sv
// port e pin assignment, direction, pull-up and reduced-drive control
//
// Function
// - direction bit set means gpio output
// - pins 1,0 input only, bits read zero
// - direction register unmapped peripheral or emulation in expanded modes
// - alternate function overrides direction bit
// - normal single chip: all pins gpio
// - normal expanded: data enable, e clock only
// - special expanded: bus controls and pipe status
// - peripheral: assignment inaccessible, clock test set
// - normal write once, special except first
// - pin 7 data enable or calibration
// - clock test on pin 6, pipe wins
// - pipe status on pins 6,5 expanded only
// - no-e-clock bit write rules by mode
// - pin 4 e clock, stretch gate in single
// - low strobe on pin 3 where allowed
// - normal narrow: pin 3 driven high
// - read/write on pin 2 outside single chip
// - calibration enable writable anytime, pin 7
// - inverted e or data enable on pin 7
// - pull-ups only on input pins
// - a/b pull-ups off on bus; map removal
// - reduced drive per port, resets zero
//
// Implementation choice: the address-and-strobe port.
`include "pebc_params.svh"

module pebc_pin_assign (
  input  wire logic                   clk_in,
  input  wire logic                   rst_in,
  input  wire logic                   ce_in,
  input  wire pebc_pkg::pebc_mode_type mode_in,
  input  wire logic                   emulate_port_e_in,
  input  wire logic                   e_stretch_select_in,
  input  wire logic [7:0]             addr_in,
  input  wire logic [7:0]             wdata_in,
  input  wire logic                   wr_in,
  input  wire logic                   rd_in,
  output logic      [7:0]             rdata_out,
  output logic                        ext_access_out,
  input  wire logic [7:0]             port_data_in,
  input  wire logic [7:0]             pin_in,
  input  wire logic                   data_bus_enable_signal_in,
  input  wire logic                   e_clock_in,
  input  wire logic                   cal_reference_in,
  input  wire logic                   clockgen_test_in,
  input  wire logic                   pipe_status_high_in,
  input  wire logic                   pipe_status_low_in,
  input  wire logic                   low_byte_strobe_in,
  input  wire logic                   read_write_in,
  input  wire logic                   background_debug_tagging_in,
  output logic      [7:0]             pin_out,
  output logic      [7:0]             pin_oe_out,
  output logic      [7:0]             pin_level_out,
  output logic      [7:0]             port_e_pullup_out,
  output logic                        port_a_pullup_out,
  output logic                        port_b_pullup_out,
  output logic                        port_h_load_out,
  output logic                        port_j_load_out,
  output logic                        port_k_pullup_out,
  output logic      [5:0]             low_drive_out,
  output logic                        low_byte_tag_out
);

  ////////////////////////////////////////////////////////////////////////////
  // mode decode

  logic mode_single;
  logic mode_expanded;
  logic mode_norm_exp;
  logic mode_narrow_norm;
  logic mode_periph;
  logic mode_special;

  assign mode_single      = (mode_in == pebc_pkg::PEBC_NORM_SINGLE) ||
                            (mode_in == pebc_pkg::PEBC_SPEC_SINGLE);
  assign mode_norm_exp    = (mode_in == pebc_pkg::PEBC_NORM_EXP_NARROW) ||
                            (mode_in == pebc_pkg::PEBC_NORM_EXP_WIDE);
  assign mode_expanded    = mode_norm_exp ||
                            (mode_in == pebc_pkg::PEBC_SPEC_EXP_NARROW) ||
                            (mode_in == pebc_pkg::PEBC_SPEC_EXP_WIDE);
  assign mode_narrow_norm = (mode_in == pebc_pkg::PEBC_NORM_EXP_NARROW);
  assign mode_periph      = (mode_in == pebc_pkg::PEBC_PERIPHERAL);
  assign mode_special     = !mode_single && !mode_norm_exp ||
                            (mode_in == pebc_pkg::PEBC_SPEC_SINGLE);

  // normal: only the very first write lands; special: every write but the first
  function automatic logic guarded_write(input logic special, input logic written);
    guarded_write = special ? written : !written;
  endfunction

  function automatic logic [7:0] assign_reset(input pebc_pkg::pebc_mode_type m);
    case (m)
      pebc_pkg::PEBC_NORM_SINGLE:     assign_reset = `PEBC_ASSIGN_RST_NSC;
      pebc_pkg::PEBC_SPEC_SINGLE:     assign_reset = `PEBC_ASSIGN_RST_SSC;
      pebc_pkg::PEBC_NORM_EXP_NARROW: assign_reset = `PEBC_ASSIGN_RST_NEX;
      pebc_pkg::PEBC_NORM_EXP_WIDE:   assign_reset = `PEBC_ASSIGN_RST_NEX;
      pebc_pkg::PEBC_SPEC_EXP_NARROW: assign_reset = `PEBC_ASSIGN_RST_SEX;
      pebc_pkg::PEBC_SPEC_EXP_WIDE:   assign_reset = `PEBC_ASSIGN_RST_SEX;
      pebc_pkg::PEBC_PERIPHERAL:      assign_reset = `PEBC_ASSIGN_RST_PER;
      default:                        assign_reset = `PEBC_ASSIGN_RST_NSC;
    endcase
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // register decode

  logic dir_mapped;
  logic assign_mapped;
  logic misc_mapped;
  logic hit_dir;
  logic hit_assign;
  logic hit_pullup;
  logic hit_drive;
  logic hit_removed;

  assign dir_mapped    = !mode_periph && !(mode_expanded && emulate_port_e_in);
  assign assign_mapped = !mode_periph;
  assign misc_mapped   = !mode_periph;

  assign hit_dir    = dir_mapped    && (addr_in == `PEBC_OFS_DIRECTION);
  assign hit_assign = assign_mapped && (addr_in == `PEBC_OFS_ASSIGN);
  assign hit_pullup = misc_mapped   && (addr_in == `PEBC_OFS_PULLUP);
  assign hit_drive  = misc_mapped   && (addr_in == `PEBC_OFS_DRIVE);
  assign hit_removed = (!dir_mapped && (addr_in == `PEBC_OFS_DIRECTION)) ||
                       (mode_periph && ((addr_in == `PEBC_OFS_ASSIGN) ||
                                        (addr_in == `PEBC_OFS_PULLUP) ||
                                        (addr_in == `PEBC_OFS_DRIVE)));

  ////////////////////////////////////////////////////////////////////////////
  // registers

  logic [7:0] direction_q;
  logic [7:0] assign_q;
  logic [7:0] pullup_q;
  logic [7:0] drive_q;
  logic       assign_written_q;
  logic       drive_written_q;

  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      direction_q <= `PEBC_DIR_RESET;
    end else if (ce_in && wr_in && hit_dir) begin
      direction_q <= wdata_in & `PEBC_DIR_MASK;
    end
  end

  // per-bit write enables of the assignment register
  logic       assign_guard;
  logic [7:0] assign_wmask;

  assign assign_guard = guarded_write(mode_special, assign_written_q);

  always_comb begin
    assign_wmask = 8'h00;
    assign_wmask[`PEBC_BIT_DBUS_DIS] = assign_guard;
    assign_wmask[`PEBC_BIT_PIPE_OE]  = assign_guard;
    assign_wmask[`PEBC_BIT_LOW_BYTE_STROBE_EN] = assign_guard;
    assign_wmask[`PEBC_BIT_RW_EN]    = assign_guard;
    assign_wmask[`PEBC_BIT_INV_E]    = assign_guard;
    assign_wmask[`PEBC_BIT_CGM_TEST] = mode_special && assign_written_q;
    assign_wmask[`PEBC_BIT_CAL_EN]   = 1'b1;
    assign_wmask[`PEBC_BIT_NO_ECLK]  =
      (mode_in == pebc_pkg::PEBC_SPEC_SINGLE) ||
      ((mode_in == pebc_pkg::PEBC_NORM_SINGLE) && !assign_written_q);
  end

  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      assign_q <= assign_reset(mode_in);
    end else if (ce_in && wr_in && hit_assign) begin
      assign_q <= (wdata_in & assign_wmask) | (assign_q & ~assign_wmask);
    end
  end

  // first-write tracking, cleared by every reset
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      assign_written_q <= 1'b0;
      drive_written_q  <= 1'b0;
    end else if (ce_in && wr_in) begin
      if (hit_assign) begin
        assign_written_q <= 1'b1;
      end
      if (hit_drive) begin
        drive_written_q <= 1'b1;
      end
    end
  end

  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      pullup_q <= `PEBC_PULLUP_RESET;
    end else if (ce_in && wr_in && hit_pullup) begin
      pullup_q <= wdata_in & `PEBC_PULLUP_MASK;
    end
  end

  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      drive_q <= `PEBC_DRIVE_RESET;
    end else if (ce_in && wr_in && hit_drive &&
                 guarded_write(mode_special, drive_written_q)) begin
      drive_q <= wdata_in & `PEBC_DRIVE_MASK;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // read port: data stand one cycle after the strobe, zero when unmapped

  logic [7:0] rd_mux;

  always_comb begin
    rd_mux = 8'h00;
    if (hit_dir) begin
      rd_mux = direction_q;
    end else if (hit_assign) begin
      rd_mux = assign_q;
    end else if (hit_pullup) begin
      rd_mux = pullup_q;
    end else if (hit_drive) begin
      rd_mux = drive_q;
    end
  end

  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      rdata_out <= 8'h00;
    end else if (ce_in) begin
      rdata_out <= rd_in ? rd_mux : 8'h00;
    end
  end

  // removed registers are handed to the external bus instead
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      ext_access_out <= 1'b0;
    end else if (ce_in) begin
      ext_access_out <= (rd_in || wr_in) && hit_removed;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // pin function selection

  logic       data_bus_enable_disable;
  logic       clockgen_test_output_enable;
  logic       pipe_status_output_enable;
  logic       no_external_e_clock;
  logic       low_strobe_pin_enable;
  logic       read_write_pin_enable;
  logic       calibration_reference_enable;
  logic       inv_e;
  logic [7:0] pin_d;
  logic [7:0] oe_d;

  assign data_bus_enable_disable  = assign_q[`PEBC_BIT_DBUS_DIS];
  assign clockgen_test_output_enable = assign_q[`PEBC_BIT_CGM_TEST];
  assign pipe_status_output_enable = assign_q[`PEBC_BIT_PIPE_OE];
  assign no_external_e_clock = assign_q[`PEBC_BIT_NO_ECLK];
  assign low_strobe_pin_enable = assign_q[`PEBC_BIT_LOW_BYTE_STROBE_EN];
  assign read_write_pin_enable  = assign_q[`PEBC_BIT_RW_EN];
  assign calibration_reference_enable  = assign_q[`PEBC_BIT_CAL_EN];
  assign inv_e = assign_q[`PEBC_BIT_INV_E];

  always_comb begin
    // gpio by default; alternate functions below override the direction bits
    pin_d = port_data_in;
    oe_d  = direction_q;
    // pin 7
    if (mode_expanded && !data_bus_enable_disable) begin
      pin_d[7] = inv_e ? !e_clock_in : data_bus_enable_signal_in;
      oe_d[7]  = 1'b1;
    end else if (calibration_reference_enable && (mode_single || mode_periph || data_bus_enable_disable)) begin
      pin_d[7] = cal_reference_in;
      oe_d[7]  = 1'b1;
    end
    // pins 6 and 5
    if (pipe_status_output_enable && mode_expanded) begin
      pin_d[6] = pipe_status_high_in;
      pin_d[5] = pipe_status_low_in;
      oe_d[6]  = 1'b1;
      oe_d[5]  = 1'b1;
    end else if (clockgen_test_output_enable && !mode_single && !mode_norm_exp) begin
      pin_d[6] = clockgen_test_in;
      oe_d[6]  = 1'b1;
    end
    // pin 4
    if (!no_external_e_clock) begin
      if (mode_periph) begin
        pin_d[4] = 1'b0;
        oe_d[4]  = 1'b0;
      end else if (!mode_single || !e_stretch_select_in) begin
        pin_d[4] = e_clock_in;
        oe_d[4]  = 1'b1;
      end
    end
    // pin 3: narrow normal mode keeps it a high output, strobe bit ignored
    if (mode_narrow_norm) begin
      pin_d[3] = 1'b1;
      oe_d[3]  = 1'b1;
    end else if (low_strobe_pin_enable && !mode_single) begin
      pin_d[3] = low_byte_strobe_in;
      oe_d[3]  = 1'b1;
    end
    // pin 2
    if (read_write_pin_enable && !mode_single) begin
      pin_d[2] = read_write_in;
      oe_d[2]  = 1'b1;
    end
    // interrupt inputs are never driven
    pin_d[1:0] = 2'b00;
    oe_d[1:0]  = 2'b00;
  end

  // reset level is mode-aware so pin 3 is already high during reset
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      pin_out    <= mode_narrow_norm ? 8'h08 : 8'h00;
      pin_oe_out <= mode_narrow_norm ? 8'h08 : 8'h00;
    end else if (ce_in) begin
      pin_out    <= pin_d;
      pin_oe_out <= oe_d;
    end
  end

  // levels stay visible on every pin, interrupt pins included
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      pin_level_out <= 8'h00;
    end else if (ce_in) begin
      pin_level_out <= pin_in;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // pull-ups and drive strength

  logic [7:0] pe_pull_d;
  logic       ab_on_bus;

  assign ab_on_bus = mode_expanded || mode_periph;

  always_comb begin
    pe_pull_d = {8{pullup_q[`PEBC_BIT_PORT_E]}} & ~oe_d & 8'h8f;
  end

  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      port_e_pullup_out <= 8'h00;
      port_a_pullup_out <= 1'b0;
      port_b_pullup_out <= 1'b0;
      port_h_load_out   <= 1'b0;
      port_j_load_out   <= 1'b0;
      port_k_pullup_out <= 1'b0;
      low_drive_out     <= 6'h00;
    end else if (ce_in) begin
      port_e_pullup_out <= pe_pull_d;
      port_a_pullup_out <= pullup_q[`PEBC_BIT_PORT_A] && !ab_on_bus;
      port_b_pullup_out <= pullup_q[`PEBC_BIT_PORT_B] && !ab_on_bus;
      port_h_load_out   <= pullup_q[`PEBC_BIT_PORT_H];
      port_j_load_out   <= pullup_q[`PEBC_BIT_PORT_J];
      port_k_pullup_out <= pullup_q[`PEBC_BIT_PORT_K];
      // order k j h e b a; independent of the function on each pin
      low_drive_out     <= {drive_q[7:4], drive_q[1:0]};
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // low-byte tag sampling at the falling edge of e

  logic e_prev_q;
  logic tag_window;

  assign tag_window = low_strobe_pin_enable && background_debug_tagging_in &&
                      ((mode_in == pebc_pkg::PEBC_SPEC_EXP_NARROW) ||
                       (mode_in == pebc_pkg::PEBC_SPEC_EXP_WIDE));

  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      e_prev_q         <= 1'b0;
      low_byte_tag_out <= 1'b0;
    end else if (ce_in) begin
      e_prev_q         <= e_clock_in;
      // pin is sampled on the clock, so the edge is seen one cycle late
      low_byte_tag_out <= tag_window && e_prev_q && !e_clock_in && !pin_in[3];
    end
  end

endmodule // pebc_pin_assign

// File: rtl/pebc_params.svh
// register offsets, reset values and field positions of the port e control block
`ifndef PEBC_PARAMS_SVH
`define PEBC_PARAMS_SVH

`define PEBC_OFS_DIRECTION  8'h09
`define PEBC_OFS_ASSIGN     8'h0a
`define PEBC_OFS_PULLUP     8'h0c
`define PEBC_OFS_DRIVE      8'h0d

`define PEBC_DIR_RESET      8'h00
`define PEBC_DIR_MASK       8'hfc
`define PEBC_PULLUP_RESET   8'h10
`define PEBC_PULLUP_MASK    8'hf3
`define PEBC_DRIVE_RESET    8'h00
`define PEBC_DRIVE_MASK     8'hf3

`define PEBC_ASSIGN_RST_NEX 8'h00
`define PEBC_ASSIGN_RST_SEX 8'h2c
`define PEBC_ASSIGN_RST_PER 8'hd0
`define PEBC_ASSIGN_RST_NSC 8'h90
`define PEBC_ASSIGN_RST_SSC 8'h2c

`define PEBC_BIT_DBUS_DIS   7
`define PEBC_BIT_CGM_TEST   6
`define PEBC_BIT_PIPE_OE    5
`define PEBC_BIT_NO_ECLK    4
`define PEBC_BIT_LOW_BYTE_STROBE_EN   3
`define PEBC_BIT_RW_EN      2
`define PEBC_BIT_CAL_EN     1
`define PEBC_BIT_INV_E      0

`define PEBC_BIT_PORT_K     7
`define PEBC_BIT_PORT_J     6
`define PEBC_BIT_PORT_H     5
`define PEBC_BIT_PORT_E     4
`define PEBC_BIT_PORT_B     1
`define PEBC_BIT_PORT_A     0

`endif

// File: rtl/pebc_pkg.sv
// types shared by the port e control block
package pebc_pkg;
  typedef enum logic [2:0] {
    PEBC_NORM_SINGLE,
    PEBC_SPEC_SINGLE,
    PEBC_NORM_EXP_NARROW,
    PEBC_NORM_EXP_WIDE,
    PEBC_SPEC_EXP_NARROW,
    PEBC_SPEC_EXP_WIDE,
    PEBC_PERIPHERAL
  } pebc_mode_type;
endpackage

// File: tb/pebc_chk.sv
// concurrent checks bound to the port e control block
module pebc_chk (
  input wire logic                    clk_in,
  input wire logic                    rst_in,
  input wire logic                    ce_in,
  input wire pebc_pkg::pebc_mode_type mode_in,
  input wire logic                    emulate_port_e_in,
  input wire logic                    background_debug_tagging_in,
  input wire logic [7:0]              addr_in,
  input wire logic                    wr_in,
  input wire logic                    rd_in,
  input wire logic [7:0]              rdata_out,
  input wire logic                    ext_access_out,
  input wire logic [7:0]              pin_in,
  input wire logic [7:0]              pin_out,
  input wire logic [7:0]              pin_oe_out,
  input wire logic [7:0]              pin_level_out,
  input wire logic [7:0]              port_e_pullup_out,
  input wire logic                    low_byte_tag_out
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge clk_in);
  endclocking
  default disable iff (rst_in);
  logic acc, hit, per, sxp, xp;
  assign acc = ce_in && (wr_in || rd_in);
  assign hit = addr_in inside {8'h09, 8'h0a, 8'h0c, 8'h0d};
  assign per = mode_in == pebc_pkg::PEBC_PERIPHERAL;
  assign sxp = mode_in inside {pebc_pkg::PEBC_SPEC_EXP_NARROW, pebc_pkg::PEBC_SPEC_EXP_WIDE};
  assign xp = sxp || mode_in inside {pebc_pkg::PEBC_NORM_EXP_NARROW,
                                     pebc_pkg::PEBC_NORM_EXP_WIDE};
  ////////////////////////////////////////////////////////////////////////////////
  a_irq_pins_input: assert property (pin_oe_out[1:0] == 2'b00)
    else $error("interrupt pin driven");
  a_level_copy: assert property (ce_in |=> pin_level_out == $past(pin_in))
    else $error("pin level not copied");
  a_read_idle: assert property ((ce_in && !rd_in) [*2] |-> rdata_out == 8'h00)
    else $error("read data without read");
  a_read_unmapped: assert property (ce_in && rd_in && !hit |=> rdata_out == 8'h00)
    else $error("unmapped read not zero");
  a_periph_external: assert property (acc && hit && per |=> ext_access_out)
    else $error("peripheral access not external");
  a_emul_external: assert property (
    acc && addr_in == 8'h09 && xp && emulate_port_e_in |=> ext_access_out)
    else $error("emulated direction access not external");
  a_narrow_high: assert property (
    ce_in && mode_in == pebc_pkg::PEBC_NORM_EXP_NARROW |=> pin_out[3] && pin_oe_out[3])
    else $error("narrow pin 3 not driven high");
  a_pullup_inputs: assert property ((port_e_pullup_out & (pin_oe_out | 8'h70)) == 8'h00)
    else $error("pull-up on output pin");
  a_tag_gated: assert property (
    ce_in && !(sxp && background_debug_tagging_in) |=> !low_byte_tag_out)
    else $error("tag outside special expanded tagging");
  a_tag_single: assert property (ce_in && low_byte_tag_out |=> !low_byte_tag_out)
    else $error("tag longer than one cycle");
  c_periph_access: cover property (acc && hit && per);
  c_emul_access: cover property (acc && xp && emulate_port_e_in);
  c_tag_seen: cover property (low_byte_tag_out);
endmodule // pebc_chk

bind pebc_pin_assign pebc_chk u_chk (
  .clk_in(clk_in), .rst_in(rst_in), .ce_in(ce_in), .mode_in(mode_in),
  .emulate_port_e_in(emulate_port_e_in),
  .background_debug_tagging_in(background_debug_tagging_in), .addr_in(addr_in),
  .wr_in(wr_in), .rd_in(rd_in), .rdata_out(rdata_out), .ext_access_out(ext_access_out),
  .pin_in(pin_in), .pin_out(pin_out), .pin_oe_out(pin_oe_out),
  .pin_level_out(pin_level_out), .port_e_pullup_out(port_e_pullup_out),
  .low_byte_tag_out(low_byte_tag_out)
);

// File: tb/pebc_far.sv
// far-side model: port e pin levels as seen on the expansion bus
module pebc_far (
  input  wire logic       clk_in,
  input  wire logic [7:0] drive_in,
  input  wire logic [7:0] oe_in,
  input  wire logic [7:0] pullup_in,
  input  wire logic       tag_low_in,
  output logic      [7:0] level_out
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] wander_q = 8'h3c;
  // released lines 7, 5, 2 and 0 wander so a stale level never reads back; lines 6, 4, 3 and 1 stay fixed
  always @(posedge clk_in) wander_q <= ~wander_q ^ 8'h5a;
  always_comb begin
    level_out = (drive_in & oe_in) | (~oe_in & (pullup_in | wander_q));
    if (tag_low_in) level_out[3] = 1'b0;
  end
endmodule // pebc_far

// File: tb/tb.sv
// self-checking bench for the port e control block
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic                    clk_in = 1'b0;
  logic                    rst_in = 1'b1;
  logic                    ce = 1'b1;
  pebc_pkg::pebc_mode_type mode = pebc_pkg::PEBC_NORM_SINGLE;
  logic                    emul = 1'b0;
  logic                    e_stretch_select = 1'b0;
  logic                    wr = 1'b0;
  logic                    rd = 1'b0;
  logic                    bdt = 1'b0;
  logic                    tlow = 1'b0;
  logic [7:0]              addr = 8'h00;
  logic [7:0]              wdata = 8'h00;
  logic [7:0]              pdata = 8'h00;
  logic [7:0]              alt = 8'h00;
  logic [7:0]              rdata, lvl, po, poe, plev, pue;
  logic [5:0]              ldrv;
  logic                    ext, pua, pub, ldh, ldj, puk, tag;
  int                      failures = 0;
  int                      cmp_count = 0;
  wire sgl = mode inside {pebc_pkg::PEBC_NORM_SINGLE, pebc_pkg::PEBC_SPEC_SINGLE};
  wire per = mode == pebc_pkg::PEBC_PERIPHERAL;
  wire nxp = mode inside {pebc_pkg::PEBC_NORM_EXP_NARROW, pebc_pkg::PEBC_NORM_EXP_WIDE};
  wire xp = !(sgl || per);
  wire spc = (xp && !nxp) || per || mode == pebc_pkg::PEBC_SPEC_SINGLE;

  pebc_pin_assign dut (
    .clk_in(clk_in), .rst_in(rst_in), .ce_in(ce), .mode_in(mode),
    .emulate_port_e_in(emul), .e_stretch_select_in(e_stretch_select), .addr_in(addr),
    .wdata_in(wdata), .wr_in(wr), .rd_in(rd), .rdata_out(rdata), .ext_access_out(ext),
    .port_data_in(pdata), .pin_in(lvl), .data_bus_enable_signal_in(alt[7]),
    .e_clock_in(alt[6]), .cal_reference_in(alt[5]), .clockgen_test_in(alt[4]),
    .pipe_status_high_in(alt[3]), .pipe_status_low_in(alt[2]),
    .low_byte_strobe_in(alt[1]), .read_write_in(alt[0]),
    .background_debug_tagging_in(bdt), .pin_out(po), .pin_oe_out(poe),
    .pin_level_out(plev), .port_e_pullup_out(pue), .port_a_pullup_out(pua),
    .port_b_pullup_out(pub), .port_h_load_out(ldh), .port_j_load_out(ldj),
    .port_k_pullup_out(puk), .low_drive_out(ldrv), .low_byte_tag_out(tag)
  );
  pebc_far u_far (.clk_in(clk_in), .drive_in(po), .oe_in(poe), .pullup_in(pue),
    .tag_low_in(tlow), .level_out(lvl));
  ////////////////////////////////////////////////////////////////////////////////
  task automatic chk(input string nm, input logic [7:0] seen, input logic [7:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      failures++;
      $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic close_out();
    $display("compares %0d mismatches %0d", cmp_count, failures);
    if (failures == 0 && cmp_count > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask
  task automatic do_reset(input pebc_pkg::pebc_mode_type m);
    @(posedge clk_in);
    mode   <= m;
    rst_in <= 1'b1;
    repeat (20) @(posedge clk_in);
    rst_in <= 1'b0;
  endtask
  task automatic bus_wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk_in);
    wr    <= 1'b1;
    addr  <= a;
    wdata <= d;
    @(posedge clk_in);
    wr    <= 1'b0;
  endtask
  task automatic rd_chk(input logic [7:0] a, input logic [7:0] e);
    @(posedge clk_in);
    rd   <= 1'b1;
    addr <= a;
    @(posedge clk_in);
    rd   <= 1'b0;
    // read data stand only in the cycle right after the strobe
    #1;
    chk("read data", rdata, e);
    chk("external", {7'h00, ext}, {7'h00, (per && a != 8'h0b) || (a == 8'h09 && xp && emul)});
  endtask
  function automatic logic [7:0] rst_assign();
    if (per) return 8'hd0;
    if (mode == pebc_pkg::PEBC_NORM_SINGLE) return 8'h90;
    return nxp ? 8'h00 : 8'h2c;
  endfunction
  function automatic logic [7:0] next_assign(input logic [7:0] cur, input logic [7:0] v,
                                             input bit first);
    logic [7:0] ok;
    ok = (spc != first) ? 8'had : 8'h00;
    ok[6] = spc && !first;
    ok[1] = 1'b1;
    ok[4] = mode == pebc_pkg::PEBC_SPEC_SINGLE || (mode == pebc_pkg::PEBC_NORM_SINGLE && first);
    if (per) ok = 8'h00;
    return (cur & ~ok) | (v & ok);
  endfunction
  function automatic logic [7:0] next_drive(input logic [7:0] cur, input logic [7:0] v,
                                            input bit first);
    logic [7:0] ok;
    ok = ((spc != first) && !per) ? 8'hf3 : 8'h00;
    return (cur & ~ok) | (v & ok);
  endfunction
  task automatic check_pins(input logic [7:0] a, input logic [7:0] dir, input logic [7:0] pu,
                            input logic [7:0] dr);
    logic [7:0] o, oe;
    o  = pdata;
    oe = dir;
    if (xp && !a[7]) begin
      oe[7] = 1'b1;
      o[7]  = a[0] ? ~alt[6] : alt[7];
    end else if (a[1] && (sgl || per || a[7])) begin
      oe[7] = 1'b1;
      o[7]  = alt[5];
    end
    if (a[5] && xp) begin
      oe[6:5] = 2'b11;
      o[6:5]  = alt[3:2];
    end else if (a[6] && !(sgl || nxp)) begin
      oe[6] = 1'b1;
      o[6]  = alt[4];
    end
    if (!a[4] && (per || !(sgl && e_stretch_select))) begin
      oe[4] = !per;
      o[4]  = alt[6];
    end
    if (mode == pebc_pkg::PEBC_NORM_EXP_NARROW) begin
      oe[3] = 1'b1;
      o[3]  = 1'b1;
    end else if (a[3] && !sgl) begin
      oe[3] = 1'b1;
      o[3]  = alt[1];
    end
    if (a[2] && !sgl) begin
      oe[2] = 1'b1;
      o[2]  = alt[0];
    end
    oe[1:0] = 2'b00;
    chk("pin enables", poe, oe);
    chk("pin drive", po & oe, o & oe);
    chk("port e pullups", pue, pu[4] ? 8'h8f & ~oe : 8'h00);
    chk("port pullups", {3'h0, puk, ldj, ldh, pub, pua}, {3'h0, pu[7:5], pu[1:0] & {2{sgl}}});
    chk("low drive", {2'h0, ldrv}, {2'h0, dr[7:4], dr[1:0]});
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  initial forever #25 clk_in = ~clk_in;
  initial begin
    repeat (100000) @(posedge clk_in);
    failures++;
    close_out();
  end
  initial begin
    logic [7:0] v, ae, de, xe, ue;
    void'($urandom(84159));
    for (int n = 0; n < 21; n++) begin
      do_reset(pebc_pkg::pebc_mode_type'(n % 7));
      ae = rst_assign();
      rd_chk(8'h0a, per ? 8'h00 : ae);
      rd_chk(8'h09, 8'h00);
      rd_chk(8'h0c, per ? 8'h00 : 8'h10);
      rd_chk(8'h0d, 8'h00);
      de = 8'h00;
      v  = 8'($urandom);
      for (int k = 0; k < 2; k++) begin
        // complement on the second pass so every protected bit is tried both ways
        bus_wr(8'h0a, v);
        ae = next_assign(ae, v, k == 0);
        bus_wr(8'h0d, v);
        de = next_drive(de, v, k == 0);
        v  = ~v;
      end
      bus_wr(8'h09, v);
      xe = per ? 8'h00 : v & 8'hfc;
      v  = 8'($urandom);
      bus_wr(8'h0c, v);
      ue = per ? 8'h10 : v & 8'hf3;
      rd_chk(8'h0a, per ? 8'h00 : ae);
      rd_chk(8'h0d, per ? 8'h00 : de);
      rd_chk(8'h09, per ? 8'h00 : xe);
      rd_chk(8'h0c, per ? 8'h00 : ue);
      @(posedge clk_in);
      alt   <= 8'($urandom);
      pdata <= 8'($urandom);
      e_stretch_select  <= 1'($urandom);
      repeat (2) @(posedge clk_in);
      #1;
      check_pins(ae, xe, ue, de);
    end
    do_reset(pebc_pkg::PEBC_NORM_EXP_WIDE);
    emul <= 1'b1;
    bus_wr(8'h09, 8'hfc);
    rd_chk(8'h09, 8'h00);
    emul <= 1'b0;
    rd_chk(8'h09, 8'h00);
    rd_chk(8'h0b, 8'h00);
    ce <= 1'b0;
    bus_wr(8'h0c, 8'hff);
    ce <= 1'b1;
    rd_chk(8'h0c, 8'h10);
    do_reset(pebc_pkg::PEBC_SPEC_EXP_WIDE);
    bdt  <= 1'b1;
    tlow <= 1'b1;
    alt  <= 8'h40;
    @(posedge clk_in);
    alt <= 8'h00;
    // tag is registered at the edge that first samples e low
    @(posedge clk_in);
    #1;
    chk("tag pulse", {7'h00, tag}, 8'h01);
    @(posedge clk_in);
    #1;
    chk("tag end", {7'h00, tag}, 8'h00);
    close_out();
  end
endmodule // tb
